// ===== design/insbuf_pkg.sv
// Constants shared by the packet insertion buffer and its quadlet RAM.
// Assumes a 40 MHz system clock and an 8-bit byte address on the register port.
package insbuf_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          IDX_W           = 6;
    localparam int          TARGET_W        = 3;
    localparam int          GAP_W           = 16;
    localparam int          OFFSET_W        = 12;
    localparam int          CYCLE_CNT_W     = 4;
    localparam int          INT_W           = 2;

    // Register byte addresses
    localparam logic [7:0]  REG_RAM_PORT    = 8'ha4;
    localparam logic [7:0]  REG_CSR         = 8'ha8;
    localparam logic [7:0]  REG_GAP_CONFIG  = 8'hac;
    localparam logic [7:0]  REG_INT_STATUS  = 8'hb0;
    localparam logic [7:0]  REG_INT_ENABLE  = 8'hb4;
    localparam logic [7:0]  REG_INT_CLEAR   = 8'hb8;

    // Control and status field positions
    localparam int          FILL_CLR_BIT    = 30;
    localparam int          FILL_IDX_LSB    = 24;
    localparam int          DRAIN_CLR_BIT   = 22;
    localparam int          DRAIN_IDX_LSB   = 16;
    localparam int          TARGET_LSB      = 8;
    localparam int          PAD_BIT         = 7;
    localparam int          ENABLE_BIT      = 6;
    localparam int          SIZE_LSB        = 0;

    // Gap time field: cycle count over cycle offset
    localparam int          GAP_OFFSET_LSB  = 0;
    localparam int          GAP_CNT_LSB     = 12;

    // Interrupt status bits
    localparam int          INT_COMPLETE    = 0;
    localparam int          INT_PAD_DONE    = 1;

    // Reset values
    localparam logic [5:0]  IDX_RESET       = 6'h00;
    localparam logic [2:0]  TARGET_RESET    = 3'h0;
    localparam logic [5:0]  SIZE_RESET      = 6'h00;
    localparam logic [15:0] GAP_RESET       = 16'h0000;
    localparam logic [1:0]  INT_RESET       = 2'h0;

    // Timing: one cycle-offset tick is 25 ns, 3072 ticks make one 76.8 us cycle
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          OFFSET_TICK_NS  = 25;
    localparam int          TICK_CLOCKS     = (OFFSET_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] OFFSET_LAST     = 12'hbff;
    localparam logic [3:0]  CYCLE_CNT_LAST  = 4'hf;

    localparam logic [31:0] PAD_QUADLET     = 32'hffff_ffff;

    typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_SEND} ins_state_t;
endpackage

// ===== design/insbuf_ram.sv
// Quadlet storage for the insertion buffer: one write port, one read port.
// Assumes the caller presents the next read address; contents are never reset.
module insbuf_ram #(
    parameter int WIDTH  = 32,
    parameter int ADDR_W = 6
) (
    input  wire logic              clk,    // System clock
    input  wire logic              clk_en, // Freezes the memory while low
    input  wire logic              we,     // Write strobe
    input  wire logic [ADDR_W-1:0] waddr,  // Write location
    input  wire logic [WIDTH-1:0]  wdata,  // Write quadlet
    input  wire logic [ADDR_W-1:0] raddr,  // Read location
    output logic      [WIDTH-1:0]  rdata   // Registered read quadlet
);
    logic [WIDTH-1:0] mem [2**ADDR_W];

    // No reset on purpose: contents stay undefined until written [R4]
    always_ff @(posedge clk) begin
        if (clk_en && we) begin
            mem[waddr] <= wdata;
        end
    end

    // Write-first bypass so a read just after a write sees the new quadlet
    always_ff @(posedge clk) begin
        if (clk_en) begin
            rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
        end
    end
endmodule // insbuf_ram

// ===== design/insbuf_ctrl.sv
// Packet insertion buffer: register port, fill/drain indices, pad fill, gap timer, insertion engine.
// Assumes a one-cycle strobed register master and a downstream sink with valid/ready.
//
// Overview of operation
// (R1) While disabled, a port write stores the quadlet at the fill index.
// (R2) Each port write while disabled advances the fill index by one.
// (R3) While enabled, port reads and writes change neither RAM nor indices.
// (R4) The RAM is never reset; contents undefined until written.
// (R5) Writing one to fill-index clear zeroes it while disabled; ignored when enabled.
// (R6) Writing one to drain-index clear zeroes it while disabled; ignored when enabled.
// (R7) Fill index reads back as a 6-bit field: next location a write updates.
// (R8) Drain index reads back as 6-bit field; during insertion, the hardware location.
// (R9) Reserved control bits ignore writes and read as zero.
// (R10) Software chooses which of eight data buffers receives the inserted packet.
// (R11) Writing one to pad fills from fill index to the end with all-ones.
// (R12) Software completes all configuration before setting insertion enable.
// (R13) Hardware clears insertion enable once an insertion completes.
// (R14) Setting insertion enable zeroes both fill and drain indices.
// (R15) Software writes the packet length in quadlets into the size field.
// (R16) When enabled, insert once the stream gap reaches the programmed gap time.
// (R17) Gap time holds cycle count in bits 15:12, cycle offset in 11:0.
// (R18) While disabled, a port read returns the quadlet at drain index, then advances.
// (R19) Insertion reads size quadlets from location zero to the selected buffer.
//
// The plain strobed port is this design's own decision.
module insbuf_ctrl (
    input  wire logic        ref_clk,      // System clock, 40 MHz
    input  wire logic        rst_n,        // Asynchronous reset, active low
    input  wire logic        clk_en,       // Freezes all state while low
    input  wire logic [7:0]  reg_addr,     // Register byte address
    input  wire logic [31:0] reg_wdata,    // Register write data
    input  wire logic        reg_wr,       // Write strobe
    input  wire logic        reg_rd,       // Read strobe
    output logic      [31:0] reg_rdata,    // Read data, cycle after the strobe
    input  wire logic        ts_valid,     // Transport stream carries data this cycle
    output logic             ins_valid,    // Inserted quadlet valid
    output logic      [31:0] ins_data,     // Inserted quadlet
    output logic             ins_last,     // Last quadlet of the packet
    output logic      [2:0]  ins_buffer,   // Destination data buffer
    input  wire logic        ins_ready,    // Sink accepts the quadlet
    output logic             irq           // Level interrupt
);
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
        hit = (addr == offs);
    endfunction

    logic                    en_q;
    logic [5:0]              fill_index_q;
    logic [5:0]              fill_index_d;
    logic [5:0]              drain_index_q;
    logic [5:0]              drain_index_d;
    logic [2:0]              target_q;
    logic [5:0]              size_q;
    logic [15:0]             gap_time_q;
    logic                    pad_active_q;
    logic [5:0]              remain_q;
    logic [11:0]             gap_off_q;
    logic [3:0]              gap_cnt_q;
    logic [1:0]              int_status_q;
    logic [1:0]              int_enable_q;
    logic [1:0]              int_event;
    logic [31:0]             ram_rdata;
    logic [31:0]             ram_wdata;
    logic                    ram_we;
    insbuf_pkg::ins_state_t  state_q;

    logic wr_port, rd_port, wr_csr, enable_set, enable_abort, sw_port_write, port_read;
    logic pad_start, pad_end, gap_ok, send_take, send_load, finish;

    assign wr_port       = reg_wr && hit(reg_addr, insbuf_pkg::REG_RAM_PORT);
    assign rd_port       = reg_rd && hit(reg_addr, insbuf_pkg::REG_RAM_PORT);
    assign wr_csr        = reg_wr && hit(reg_addr, insbuf_pkg::REG_CSR);
    // Software is trusted to have set map, size and RAM beforehand [R12]
    assign enable_set    = wr_csr && reg_wdata[insbuf_pkg::ENABLE_BIT] && !en_q;
    assign enable_abort  = wr_csr && !reg_wdata[insbuf_pkg::ENABLE_BIT] && en_q;
    // Port access only counts while disabled; pad fill owns the write port [R3]
    assign sw_port_write = wr_port && !en_q && !pad_active_q;
    assign port_read     = rd_port && !en_q;
    assign pad_start     = wr_csr && reg_wdata[insbuf_pkg::PAD_BIT] && !en_q && !enable_set;
    assign pad_end       = pad_active_q && (fill_index_q == 6'h3f);

    // Gap length in cycle-timer format compared against the programmed time [R16] [R17]
    assign gap_ok        = {gap_cnt_q, gap_off_q} >= gap_time_q;
    assign send_take     = (state_q == insbuf_pkg::ST_SEND) && ins_valid && ins_ready;
    assign send_load     = ((state_q == insbuf_pkg::ST_GAP) && gap_ok && size_q != 6'h00)
                         || (send_take && remain_q != 6'h00);
    assign finish        = ((state_q == insbuf_pkg::ST_GAP) && gap_ok && size_q == 6'h00)
                         || (send_take && remain_q == 6'h00);

    assign ram_we        = pad_active_q || sw_port_write;                                // [R1]
    assign ram_wdata     = pad_active_q ? insbuf_pkg::PAD_QUADLET : reg_wdata;            // [R11]

    always_comb begin
        fill_index_d = fill_index_q;
        if (enable_set) begin
            fill_index_d = insbuf_pkg::IDX_RESET;                                         // [R14]
        end else if (wr_csr && reg_wdata[insbuf_pkg::FILL_CLR_BIT] && !en_q) begin
            fill_index_d = insbuf_pkg::IDX_RESET;                                         // [R5]
        end else if (ram_we) begin
            fill_index_d = fill_index_q + 6'h01;                                          // [R2]
        end
    end

    always_comb begin
        drain_index_d = drain_index_q;
        if (enable_set) begin
            drain_index_d = insbuf_pkg::IDX_RESET;                                        // [R14]
        end else if (wr_csr && reg_wdata[insbuf_pkg::DRAIN_CLR_BIT] && !en_q) begin
            drain_index_d = insbuf_pkg::IDX_RESET;                                        // [R6]
        end else if (port_read || send_load) begin
            drain_index_d = drain_index_q + 6'h01;                                        // [R18] [R19]
        end
    end

    // Read address runs one step ahead so the RAM register always holds the drain location
    insbuf_ram #(
        .WIDTH  (insbuf_pkg::DATA_W),
        .ADDR_W (insbuf_pkg::IDX_W)
    ) u_ram (
        .clk    (ref_clk),
        .clk_en (clk_en),
        .we     (ram_we),
        .waddr  (fill_index_q),
        .wdata  (ram_wdata),
        .raddr  (drain_index_d),
        .rdata  (ram_rdata)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_index_q  <= insbuf_pkg::IDX_RESET;
            drain_index_q <= insbuf_pkg::IDX_RESET;
        end else if (clk_en) begin
            fill_index_q  <= fill_index_d;
            drain_index_q <= drain_index_d;
        end
    end

    // Configuration fields; clear bits and pad are self-clearing so not stored [R9]
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            target_q   <= insbuf_pkg::TARGET_RESET;
            size_q     <= insbuf_pkg::SIZE_RESET;
            gap_time_q <= insbuf_pkg::GAP_RESET;
        end else if (clk_en) begin
            if (wr_csr) begin
                target_q <= reg_wdata[insbuf_pkg::TARGET_LSB +: insbuf_pkg::TARGET_W];   // [R10]
                size_q   <= reg_wdata[insbuf_pkg::SIZE_LSB +: insbuf_pkg::IDX_W];        // [R15]
            end
            if (reg_wr && hit(reg_addr, insbuf_pkg::REG_GAP_CONFIG)) begin
                gap_time_q <= reg_wdata[insbuf_pkg::GAP_OFFSET_LSB +: insbuf_pkg::GAP_W];
            end
        end
    end

    // Pad fill writes one quadlet per cycle up to the last location
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_active_q <= 1'b0;
        end else if (clk_en) begin
            if (enable_set || pad_end) begin
                pad_active_q <= 1'b0;
            end else if (pad_start) begin
                pad_active_q <= 1'b1;                                                     // [R11]
            end
        end
    end

    // Idle-stream timer; offset steps once per 25 ns tick, count saturates
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_off_q <= 12'h000;
            gap_cnt_q <= 4'h0;
        end else if (clk_en) begin
            if (ts_valid) begin
                gap_off_q <= 12'h000;
                gap_cnt_q <= 4'h0;
            end else if (gap_off_q != insbuf_pkg::OFFSET_LAST) begin
                gap_off_q <= gap_off_q + 12'(insbuf_pkg::TICK_CLOCKS);                   // [R17]
            end else if (gap_cnt_q != insbuf_pkg::CYCLE_CNT_LAST) begin
                gap_off_q <= 12'h000;
                gap_cnt_q <= gap_cnt_q + 4'h1;
            end
        end
    end

    // Enable bit: a software set wins over the hardware clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
        end else if (clk_en) begin
            if (enable_set) begin
                en_q <= 1'b1;
            end else if (finish || enable_abort) begin
                en_q <= 1'b0;                                                             // [R13]
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= insbuf_pkg::ST_IDLE;
            remain_q   <= 6'h00;
            ins_valid  <= 1'b0;
            ins_data   <= 32'h0000_0000;
            ins_last   <= 1'b0;
            ins_buffer <= insbuf_pkg::TARGET_RESET;
        end else if (clk_en) begin
            case (state_q)
                insbuf_pkg::ST_IDLE: begin
                    if (enable_set) begin
                        state_q <= insbuf_pkg::ST_GAP;
                    end
                end
                insbuf_pkg::ST_GAP: begin
                    if (enable_abort || finish) begin
                        state_q <= insbuf_pkg::ST_IDLE;
                    end else if (send_load) begin
                        state_q    <= insbuf_pkg::ST_SEND;                                // [R16]
                        ins_valid  <= 1'b1;
                        ins_data   <= ram_rdata;                                          // [R19]
                        ins_last   <= (size_q == 6'h01);
                        ins_buffer <= target_q;
                        remain_q   <= size_q - 6'h01;
                    end
                end
                insbuf_pkg::ST_SEND: begin
                    if (enable_abort || finish) begin
                        state_q   <= insbuf_pkg::ST_IDLE;
                        ins_valid <= 1'b0;
                        ins_last  <= 1'b0;
                    end else if (send_load) begin
                        ins_data <= ram_rdata;                                            // [R19]
                        ins_last <= (remain_q == 6'h01);
                        remain_q <= remain_q - 6'h01;
                    end
                end
                default: begin
                    state_q   <= insbuf_pkg::ST_IDLE;
                    ins_valid <= 1'b0;
                end
            endcase
        end
    end

    assign int_event[insbuf_pkg::INT_COMPLETE] = finish;
    assign int_event[insbuf_pkg::INT_PAD_DONE] = pad_end;

    // Sticky status; a new event beats a clear in the same cycle
    for (genvar i = 0; i < insbuf_pkg::INT_W; i++) begin : g_int
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                int_status_q[i] <= 1'b0;
            end else if (clk_en) begin
                if (int_event[i]) begin
                    int_status_q[i] <= 1'b1;
                end else if (reg_wr && hit(reg_addr, insbuf_pkg::REG_INT_CLEAR) && reg_wdata[i]) begin
                    int_status_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_enable_q <= insbuf_pkg::INT_RESET;
            irq          <= 1'b0;
        end else if (clk_en) begin
            if (reg_wr && hit(reg_addr, insbuf_pkg::REG_INT_ENABLE)) begin
                int_enable_q <= reg_wdata[insbuf_pkg::INT_W-1:0];
            end
            irq <= |(int_status_q & int_enable_q);
        end
    end

    // Read mux; unmapped addresses and write-only registers return zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (clk_en && reg_rd) begin
            reg_rdata <= 32'h0000_0000;
            if (hit(reg_addr, insbuf_pkg::REG_RAM_PORT)) begin
                reg_rdata <= en_q ? 32'h0000_0000 : ram_rdata;                            // [R18]
            end else if (hit(reg_addr, insbuf_pkg::REG_CSR)) begin
                reg_rdata[insbuf_pkg::FILL_IDX_LSB +: insbuf_pkg::IDX_W]  <= fill_index_q;  // [R7]
                reg_rdata[insbuf_pkg::DRAIN_IDX_LSB +: insbuf_pkg::IDX_W] <= drain_index_q; // [R8]
                reg_rdata[insbuf_pkg::TARGET_LSB +: insbuf_pkg::TARGET_W] <= target_q;
                reg_rdata[insbuf_pkg::ENABLE_BIT]                         <= en_q;
                reg_rdata[insbuf_pkg::SIZE_LSB +: insbuf_pkg::IDX_W]      <= size_q;
            end else if (hit(reg_addr, insbuf_pkg::REG_GAP_CONFIG)) begin
                reg_rdata[insbuf_pkg::GAP_W-1:0] <= gap_time_q;
            end else if (hit(reg_addr, insbuf_pkg::REG_INT_STATUS)) begin
                reg_rdata[insbuf_pkg::INT_W-1:0] <= int_status_q;
            end else if (hit(reg_addr, insbuf_pkg::REG_INT_ENABLE)) begin
                reg_rdata[insbuf_pkg::INT_W-1:0] <= int_enable_q;
            end
        end
    end

    a_port_write_adv: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
        clk_en && sw_port_write && !pad_active_q |=> fill_index_q == $past(fill_index_q) + 6'h01)
        else $error("fill index did not advance after port write");
    a_enabled_no_ram: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
        en_q |-> !ram_we)
        else $error("RAM written while insertion enabled");
    a_enabled_fill_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
        clk_en && en_q && !finish && !enable_abort |=> $stable(fill_index_q))
        else $error("fill index moved while enabled");
    a_fill_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
        clk_en && wr_csr && reg_wdata[insbuf_pkg::FILL_CLR_BIT] && !en_q |=> fill_index_q == 6'h00)
        else $error("fill index clear failed");
    a_drain_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
        clk_en && wr_csr && reg_wdata[insbuf_pkg::DRAIN_CLR_BIT] && !en_q |=> drain_index_q == 6'h00)
        else $error("drain index clear failed");
    a_csr_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
        clk_en && reg_rd && hit(reg_addr, insbuf_pkg::REG_CSR)
        |=> reg_rdata[31] == 1'b0 && reg_rdata[23:22] == 2'b00 && reg_rdata[15:11] == 5'h00)
        else $error("reserved control bits read nonzero");
    a_pad_ones: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
        pad_active_q |-> ram_we && ram_wdata == 32'hffff_ffff)
        else $error("pad fill did not write all ones");
    a_done_clears_en: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
        clk_en && send_take && remain_q == 6'h00 |=> !en_q && int_status_q[0] && !ins_valid)
        else $error("enable not cleared after insertion");
    a_enable_zeroes: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
        clk_en && enable_set |=> en_q && fill_index_q == 6'h00 && drain_index_q == 6'h00)
        else $error("enable did not zero indices");
    a_gap_wait: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
        state_q == insbuf_pkg::ST_GAP && !gap_ok |=> !ins_valid)
        else $error("insertion started before gap time");
    a_read_adv: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R18]
        clk_en && port_read |=> drain_index_q == $past(drain_index_q) + 6'h01 && reg_rdata == $past(ram_rdata))
        else $error("port read wrong data or index");
endmodule // insbuf_ctrl

// ===== tb/packet_insertion_buffer_tb_top.sv
// Self-checking bench for the packet insertion buffer controller.
// Assumes insbuf_pkg and insbuf_ctrl are compiled first; clk_en drops only for one frozen write.
module packet_insertion_buffer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    logic        clk_en    = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        ts_valid  = 1'b1;
    logic        ins_ready = 1'b0;
    logic [31:0] reg_rdata, ins_data, d;
    logic        ins_valid, ins_last, irq;
    logic [2:0]  ins_buffer;
    int          errors     = 0;
    int          num_checks = 0;
    int          n;

    insbuf_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ts_valid(ts_valid), .ins_valid(ins_valid), .ins_data(ins_data), .ins_last(ins_last),
        .ins_buffer(ins_buffer), .ins_ready(ins_ready), .irq(irq));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data is loaded at the edge after the strobe and holds until the next read, so sample just past that edge
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic t_reset;
        rd(insbuf_pkg::REG_CSR, d); chk(d, 32'h0000_0000);
        rd(insbuf_pkg::REG_GAP_CONFIG, d); chk(d, 32'h0000_0000);
        rd(8'hfc, d); chk(d, 32'h0000_0000);
        wr(insbuf_pkg::REG_CSR, 32'h8080_f800);
        rd(insbuf_pkg::REG_CSR, d); chk(d, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_pad;
        wr(insbuf_pkg::REG_INT_ENABLE, 32'h0000_0002);
        wr(insbuf_pkg::REG_CSR, 32'h0000_0080);
        repeat (70) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(insbuf_pkg::REG_INT_STATUS, d); chk(d, 32'h0000_0002);
        rd(insbuf_pkg::REG_CSR, d); chk(d, 32'h0000_0000);
        wr(insbuf_pkg::REG_INT_CLEAR, 32'h0000_0002);
        rd(insbuf_pkg::REG_INT_STATUS, d); chk(d, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            rd(insbuf_pkg::REG_RAM_PORT, d); chk(d, insbuf_pkg::PAD_QUADLET);
        end
        $display("test pad done");
    endtask

    task automatic t_fill;
        wr(insbuf_pkg::REG_CSR, 32'h4040_0000);
        rd(insbuf_pkg::REG_CSR, d); chk(d, 32'h0000_0000);
        for (int i = 0; i < 3; i++) wr(insbuf_pkg::REG_RAM_PORT, 32'hc0de_0000 + i);
        // A write while the clock enable is low must be lost
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(insbuf_pkg::REG_RAM_PORT, 32'hdead_0000);
        clk_en <= 1'b1;
        rd(insbuf_pkg::REG_CSR, d); chk(d, 32'h0300_0000);
        for (int i = 0; i < 3; i++) begin
            rd(insbuf_pkg::REG_RAM_PORT, d); chk(d, 32'hc0de_0000 + i);
        end
        rd(insbuf_pkg::REG_RAM_PORT, d); chk(d, insbuf_pkg::PAD_QUADLET);
        rd(insbuf_pkg::REG_CSR, d); chk(d, 32'h0304_0000);
        $display("test fill done");
    endtask

    task automatic t_insert;
        wr(insbuf_pkg::REG_GAP_CONFIG, 32'h0000_0003);
        wr(insbuf_pkg::REG_INT_ENABLE, 32'h0000_0001);
        wr(insbuf_pkg::REG_CSR, 32'h0000_0542);
        rd(insbuf_pkg::REG_CSR, d); chk(d, 32'h0000_0542);
        wr(insbuf_pkg::REG_RAM_PORT, 32'h1234_5678);
        rd(insbuf_pkg::REG_RAM_PORT, d); chk(d, 32'h0000_0000);
        wr(insbuf_pkg::REG_CSR, 32'h4040_0542);
        rd(insbuf_pkg::REG_CSR, d); chk(d, 32'h0000_0542);
        // Stream busy so far; a gap opens now and must last three offset ticks
        @(posedge ref_clk);
        ts_valid  <= 1'b0;
        ins_ready <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (ins_valid !== 1'b1 && n < 50);
        chk(n, 32'h0000_0004);
        chk(ins_data, 32'hc0de_0000);
        chk({28'h0, ins_last, ins_buffer}, 32'h0000_0005);
        @(posedge ref_clk);
        #1 chk(ins_data, 32'hc0de_0001);
        chk({28'h0, ins_last, ins_buffer}, 32'h0000_000d);
        @(posedge ref_clk);
        #1 chk({31'h0, ins_valid}, 32'h0000_0000);
        repeat (3) @(posedge ref_clk);
        ts_valid <= 1'b1;
        rd(insbuf_pkg::REG_CSR, d); chk(d & 32'h0000_ffff, 32'h0000_0502);
        rd(insbuf_pkg::REG_INT_STATUS, d); chk(d, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(insbuf_pkg::REG_INT_CLEAR, 32'h0000_0001);
        rd(insbuf_pkg::REG_INT_CLEAR, d); chk(d, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        // Enable then abort while the stream is busy: indices zeroed, no completion
        wr(insbuf_pkg::REG_CSR, 32'h0000_0042);
        wr(insbuf_pkg::REG_CSR, 32'h0000_0002);
        rd(insbuf_pkg::REG_CSR, d); chk(d, 32'h0000_0002);
        rd(insbuf_pkg::REG_INT_STATUS, d); chk(d, 32'h0000_0000);
        $display("test insert done");
    endtask

    // Gap of one whole cycle count: 3072 offset ticks before the count field steps
    task automatic t_long_gap;
        wr(insbuf_pkg::REG_GAP_CONFIG, 32'h0000_1000);
        wr(insbuf_pkg::REG_CSR, 32'h0000_0341);
        @(posedge ref_clk);
        ts_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (ins_valid !== 1'b1 && n < 4000);
        chk(n, 32'h0000_0c01);
        chk(ins_data, 32'hc0de_0000);
        chk({28'h0, ins_last, ins_buffer}, 32'h0000_000b);
        @(posedge ref_clk);
        ts_valid <= 1'b1;
        #1 chk({31'h0, ins_valid}, 32'h0000_0000);
        $display("test long gap done");
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #1_000_000;
        errors++;
        close_out;
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset;
        t_pad;
        t_fill;
        t_insert;
        t_long_gap;
        close_out;
    end
endmodule // packet_insertion_buffer_tb_top
